// ===== inc/regulator_ctrl_pkg.sv
/*
  Constants, encodings and the state type shared by the regulator control block.
  Assumes a 50 MHz control clock.
*/
package regulator_ctrl_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 50;
  localparam int CLK_HZ = 50_000_000;
  localparam int EDGE_HOLD_NS = 100;
  localparam int EDGE_CYC = (EDGE_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_NS = 4000;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_F_MIN_HZ = 200_000;
  localparam int SYNC_F_MAX_HZ = 2_200_000;
  localparam int SYNC_PER_MIN = (CLK_HZ + SYNC_F_MAX_HZ - 1) / SYNC_F_MAX_HZ;
  localparam int SYNC_PER_MAX = CLK_HZ / SYNC_F_MIN_HZ;
  localparam int LOCK_EDGES = 2048;
  localparam int PG_FILT_US = 120;
  localparam int PG_FILT_CYC = PG_FILT_US * CLK_MHZ;
  localparam int PG_REL_US = 2000;
  localparam int PG_REL_CYC = PG_REL_US * CLK_MHZ;
  localparam int DEF_PERIOD = 125;

  // ==========================================================
  // Synchronised input bit positions
  localparam int IN_WAKE = 0;
  localparam int IN_EN = 1;
  localparam int IN_VIN_OK = 2;
  localparam int IN_VIN_MIN = 3;
  localparam int IN_RT_OK = 4;
  localparam int IN_FB_WIN = 5;
  localparam int IN_ILIM = 6;
  localparam int IN_TSD = 7;
  localparam int IN_SS_DONE = 8;
  localparam int IN_MIN_TIME = 9;
  localparam int IN_W = 10;

  // ==========================================================
  // Operating modes and state
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'h0,
    MODE_STANDBY = 2'h1,
    MODE_SWITCHING = 2'h2
  } mode_t;

  typedef struct packed {
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
    logic en_filt;
    logic [2:0] edge_cnt;
    logic [7:0] blank_cnt;
    logic en_state;
    mode_t mode;
    logic vcc_on;
    logic sw_on;
    logic [7:0] sync_gap;
    logic [11:0] edge_total;
    logic locked;
    logic [7:0] period;
    logic [8:0] osc_cnt;
    logic sw_pulse;
    logic spread_on;
    logic pg_oe;
    logic [15:0] flt_cnt;
    logic [16:0] rel_cnt;
  } ctrl_state_t;

endpackage : regulator_ctrl_pkg

// ===== rtl/regulator_ctrl.sv
/*
  Control logic of a step-down regulator: enable/sync decoding with blanking,
  oscillator lock to an external clock, and the open-drain power-good flag.
  Assumes all status inputs are asynchronous levels from analog comparators.
*/
// Contract
// - Enable below wake threshold keeps the device in shutdown.
// - Between thresholds supply is on, switch idle; above enable switch if input good.
// - After an enable-pin clock edge, enable changes are ignored for the blanking time.
// - No blanking is applied while in shutdown.
// - Sync clock lies within 200 kHz to 2.2 MHz and is followed.
// - After 2048 valid sync cycles the oscillator takes the sync frequency.
// - Valid sync disables frequency spreading.
// - Changeover keeps phase so the transitional cycle is intermediate.
// - Phase then slides gradually until switch pulses align with sync rises.
// - Resistor pin out of range forces shutdown.
// - Frequency drops when minimum on or off time limits the ratio.
// - Power-good pulls low on any fault, disable or start-up.
// - Short feedback excursions under the filter time do not trip power-good.
// - Power-good is open-drain pull-down, forced low when enable is low.
// - Power-good stays valid while disabled down to about 1 V input.
// - Power-good releases 2 ms after regulation returns.
// - Power-good fault filter time is 120 us.
`timescale 1ns/10ps
module regulator_ctrl #(
  parameter int PG_FILT = regulator_ctrl_pkg::PG_FILT_CYC,
  parameter int PG_REL = regulator_ctrl_pkg::PG_REL_CYC,
  parameter logic [7:0] RT_PERIOD = 8'(regulator_ctrl_pkg::DEF_PERIOD)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic en_wake,
  input wire logic en_sync_pin,
  input wire logic vin_ok,
  input wire logic vin_min_ok,
  input wire logic freq_set_resistor_pin_ok,
  input wire logic fb_in_window,
  input wire logic current_limit,
  input wire logic thermal_shutdown,
  input wire logic soft_start_done,
  input wire logic min_time_limited,
  output regulator_ctrl_pkg::mode_t mode,
  output logic vcc_enable,
  output logic switch_node_enable,
  output logic switch_pulse,
  output logic spread_enable,
  output logic sync_locked,
  output logic power_good_flag_out,
  output logic power_good_flag_oe
);
  import regulator_ctrl_pkg::*;

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic hard_fault;
  logic [8:0] period_eff;
  logic sync_rise;
  logic [7:0] meas;
  logic meas_ok;

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.s1 = {min_time_limited, soft_start_done, thermal_shutdown, current_limit,
                  fb_in_window, freq_set_resistor_pin_ok, vin_min_ok, vin_ok,
                  en_sync_pin, en_wake};
    next_st.s2 = st.s1;

    // Edge recognition: a new level must hold before it counts.
    if (st.s2[IN_EN] == st.en_filt) begin
      next_st.edge_cnt = 3'h0;
    end else if (st.edge_cnt == 3'(EDGE_CYC - 1)) begin
      next_st.edge_cnt = 3'h0;
      next_st.en_filt = st.s2[IN_EN];
    end else begin
      next_st.edge_cnt = st.edge_cnt + 3'h1;
    end
    sync_rise = next_st.en_filt && !st.en_filt;

    if (st.mode == MODE_SHUTDOWN) begin
      next_st.blank_cnt = 8'h00;
      next_st.en_state = st.en_filt;
    end else if (next_st.en_filt != st.en_filt) begin
      next_st.blank_cnt = 8'(BLANK_CYC);
    end else if (st.blank_cnt != 8'h00) begin
      next_st.blank_cnt = st.blank_cnt - 8'h01;
    end else begin
      next_st.en_state = st.en_filt;
    end

    if (!st.s2[IN_WAKE] || !st.s2[IN_RT_OK]) begin
      next_st.mode = MODE_SHUTDOWN;
    end else if (st.en_state && st.s2[IN_VIN_OK]) begin
      next_st.mode = MODE_SWITCHING;
    end else begin
      next_st.mode = MODE_STANDBY;
    end
    // Decoded mode outputs are registered so that no pin sees a decode glitch.
    next_st.vcc_on = next_st.mode != MODE_SHUTDOWN;
    next_st.sw_on = next_st.mode == MODE_SWITCHING;

    // Sync period measurement; a gap past the slowest legal clock drops lock.
    meas = st.sync_gap + 8'h01;
    meas_ok = (meas >= 8'(SYNC_PER_MIN)) && (meas <= 8'(SYNC_PER_MAX));
    if (sync_rise) begin
      next_st.sync_gap = 8'h00;
      if (!meas_ok) begin
        next_st.edge_total = 12'h000;
      end else if (st.locked) begin
        next_st.period = meas;
      end else if (st.edge_total == 12'(LOCK_EDGES - 1)) begin
        next_st.locked = 1'b1;
        next_st.period = meas;
      end else begin
        next_st.edge_total = st.edge_total + 12'h001;
      end
    end else if (st.sync_gap > 8'(SYNC_PER_MAX)) begin
      next_st.edge_total = 12'h000;
      next_st.locked = 1'b0;
      next_st.period = RT_PERIOD;
    end else begin
      next_st.sync_gap = st.sync_gap + 8'h01;
    end
    if (st.mode != MODE_SWITCHING && !st.locked) begin
      next_st.period = RT_PERIOD;
    end

    // The count is kept across a period change, so the cycle in flight ends at
    // whichever limit it meets: an intermediate length, never a runt or gap.
    period_eff = {1'b0, st.period} + (st.s2[IN_MIN_TIME] ? 9'(st.period >> 2) : 9'h000);
    next_st.sw_pulse = 1'b0;
    if (st.mode != MODE_SWITCHING) begin
      next_st.osc_cnt = 9'h000;
    end else if (st.osc_cnt >= period_eff - 9'h001) begin
      next_st.osc_cnt = 9'h000;
      next_st.sw_pulse = 1'b1;
    end else if (st.locked && sync_rise && st.osc_cnt < {1'b0, st.period[7:1]}) begin
      next_st.osc_cnt = st.osc_cnt;
    end else if (st.locked && sync_rise) begin
      next_st.osc_cnt = st.osc_cnt + 9'h002;
    end else begin
      next_st.osc_cnt = st.osc_cnt + 9'h001;
    end
    next_st.spread_on = (st.mode == MODE_SWITCHING) && !st.locked && !st.s2[IN_MIN_TIME];

    // Power-good: hard faults act at once, feedback excursions are filtered.
    hard_fault = !st.en_state || st.mode != MODE_SWITCHING || st.s2[IN_TSD] ||
                 st.s2[IN_ILIM] || !st.s2[IN_SS_DONE];
    if (st.s2[IN_FB_WIN]) begin
      next_st.flt_cnt = 16'h0000;
    end else if (st.flt_cnt != 16'(PG_FILT)) begin
      next_st.flt_cnt = st.flt_cnt + 16'h0001;
    end
    if (hard_fault || st.flt_cnt == 16'(PG_FILT)) begin
      next_st.pg_oe = 1'b1;
      next_st.rel_cnt = 17'h00000;
    end else if (st.pg_oe && !st.s2[IN_FB_WIN]) begin
      next_st.rel_cnt = 17'h00000;
    end else if (st.pg_oe && st.rel_cnt == 17'(PG_REL - 1)) begin
      next_st.pg_oe = 1'b0;
    end else if (st.pg_oe) begin
      next_st.rel_cnt = st.rel_cnt + 17'h00001;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '0;
      st.mode <= MODE_SHUTDOWN;
      st.period <= RT_PERIOD;
      st.pg_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign mode = st.mode;
  assign vcc_enable = st.vcc_on;
  assign switch_node_enable = st.sw_on;
  assign switch_pulse = st.sw_pulse;
  assign spread_enable = st.spread_on;
  assign sync_locked = st.locked;
  assign power_good_flag_out = 1'b0;
  assign power_good_flag_oe = st.pg_oe;

  // ==========================================================
  // Checks
  chk_wake_shutdown: assert property (@(posedge clk) disable iff (!reset_n)
    !st.s2[IN_WAKE] |=> st.mode == MODE_SHUTDOWN) else $error("not in shutdown below wake");
  chk_switch_cause: assert property (@(posedge clk) disable iff (!reset_n)
    (st.mode != MODE_SWITCHING && !(st.en_state && st.s2[IN_VIN_OK])) |=>
    st.mode != MODE_SWITCHING) else $error("switching without enable and input");
  chk_blank_holds: assert property (@(posedge clk) disable iff (!reset_n)
    (st.blank_cnt != 8'h00 && st.mode != MODE_SHUTDOWN) |=> $stable(st.en_state))
    else $error("enable changed in blanking");
  chk_no_blank_sd: assert property (@(posedge clk) disable iff (!reset_n)
    st.mode == MODE_SHUTDOWN |=> st.blank_cnt == 8'h00) else $error("blanking in shutdown");
  chk_lock_count: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st.locked) |-> $past(st.edge_total) == 12'(LOCK_EDGES - 1))
    else $error("lock at wrong edge count");
  chk_sync_restart: assert property (@(posedge clk) disable iff (!reset_n)
    (sync_rise && !meas_ok) |=> st.edge_total == 12'h000)
    else $error("sync count not restarted");
  chk_spread_off: assert property (@(posedge clk) disable iff (!reset_n)
    st.locked |=> !st.spread_on) else $error("spreading while locked");
  chk_rt_shutdown: assert property (@(posedge clk) disable iff (!reset_n)
    !st.s2[IN_RT_OK] |=> st.mode == MODE_SHUTDOWN) else $error("bad resistor not shut down");
  chk_pg_en_low: assert property (@(posedge clk) disable iff (!reset_n)
    !st.en_state |=> st.pg_oe) else $error("power-good released with enable low");
  chk_pg_fault_cause: assert property (@(posedge clk) disable iff (!reset_n)
    (!st.pg_oe && !hard_fault && st.flt_cnt != 16'(PG_FILT)) |=> !st.pg_oe)
    else $error("power-good fell without cause");
  chk_pg_release: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(st.pg_oe) |-> $past(st.rel_cnt) == 17'(PG_REL - 1)) else $error("early release");

endmodule : regulator_ctrl

// ===== tb/sync_source.sv
/* Model of the party that drives the shared enable/sync pin.
   Assumes the bench sets run, level and the half period in ns. */
`timescale 1ns/10ps
module sync_source (
  input wire logic run,
  input wire logic level,
  input var int half_ns,
  output logic pin
);
  // ==========================================
  // Pin driver
  // The clock stands still at the level when not running, so no stray edge
  // is seen outside a burst.
  initial begin
    forever begin
      if (run) begin
        #(half_ns) pin = ~pin;
      end else begin
        pin = level;
        @(run or level);
      end
    end
  end
endmodule : sync_source

// ===== tb/regulator_ctrl_tb_top.sv
/* Self-checking bench for the regulator control block.
   Assumes the package, the design and the sync source model. */
`timescale 1ns/10ps
module regulator_ctrl_tb_top;
  import regulator_ctrl_pkg::*;
  localparam int PG_F = 20;
  localparam int PG_R = 40;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic en_wake = 1'b0;
  logic run = 1'b0;
  logic level = 1'b0;
  int half = 250;
  logic pin;
  logic [6:0] st = 7'h03;
  mode_t mode;
  logic vcc_en, sw_en, sw_p, spread, locked, pg_out, pg_oe;
  int error_cnt = 0;
  int num_checks = 0;
  logic [31:0] rs = 32'h3b;
  int n;
  always #10 clk = ~clk;
  sync_source SRC (.run(run), .level(level), .half_ns(half), .pin(pin));
  regulator_ctrl #(.PG_FILT(PG_F), .PG_REL(PG_R)) DUT (
    .clk(clk), .reset_n(reset_n), .en_wake(en_wake), .en_sync_pin(pin),
    .vin_ok(st[0]), .freq_set_resistor_pin_ok(st[1]), .current_limit(st[2]),
    .thermal_shutdown(st[3]), .fb_in_window(st[4]), .soft_start_done(st[5]),
    .min_time_limited(st[6]), .vin_min_ok(1'b1), .mode(mode),
    .vcc_enable(vcc_en), .switch_node_enable(sw_en), .switch_pulse(sw_p),
    .spread_enable(spread), .sync_locked(locked),
    .power_good_flag_out(pg_out), .power_good_flag_oe(pg_oe));
  // ==========================================
  // Helpers
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  function automatic int fold_per(int p);
    return p + p / 4;
  endfunction : fold_per
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic wait_mode(mode_t m, int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(negedge clk);
    chk("mode", m, mode);
  endtask : wait_mode
  task automatic wait_oe(logic v, int lim);
    for (int i = 0; i < lim && pg_oe !== v; i++) @(negedge clk);
    chk("pg_oe", v, pg_oe);
  endtask : wait_oe
  task automatic pulses(int k);
    n = 0;
    repeat (k) begin
      @(negedge clk);
      n += (sw_p === 1'b1);
    end
  endtask : pulses
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  initial begin
    #1900000;
    error_cnt++;
    close_out();
  end
  // ==========================================
  // Scenarios
  initial begin
    cyc(3);
    @(posedge clk) reset_n <= 1'b1;
    cyc(1);
    chk("mode", MODE_SHUTDOWN, mode);
    chk("pg_oe", 1, pg_oe);
    chk("pg_out", 0, pg_out);
    @(posedge clk) en_wake <= 1'b1;
    wait_mode(MODE_STANDBY, 40);
    chk("vcc", 1, vcc_en);
    chk("sw_en", 0, sw_en);
    @(posedge clk) en_wake <= 1'b0;
    wait_mode(MODE_SHUTDOWN, 40);
    @(posedge clk) level <= 1'b1;
    cyc(20);
    @(posedge clk) en_wake <= 1'b1;
    wait_mode(MODE_SWITCHING, 40);
    for (int b = 0; b < 2; b++) begin
      @(posedge clk) st[b] <= 1'b0;
      wait_mode(b ? MODE_SHUTDOWN : MODE_STANDBY, 40);
      @(posedge clk) st[b] <= 1'b1;
      wait_mode(MODE_SWITCHING, 300);
    end
    @(posedge clk) st[5:4] <= 2'b11;
    cyc(PG_R - 10);
    chk("pg_oe", 1, pg_oe);
    wait_oe(0, 20);
    repeat (4) begin
      rs = xs(rs);
      @(posedge clk) st[4] <= 1'b0;
      cyc(1 + rs % 15);
      @(posedge clk) st[4] <= 1'b1;
      cyc(PG_F);
      chk("pg_oe", 0, pg_oe);
    end
    @(posedge clk) st[4] <= 1'b0;
    cyc(PG_F - 6);
    chk("pg_oe", 0, pg_oe);
    wait_oe(1, 12);
    @(posedge clk) st[4] <= 1'b1;
    wait_oe(0, PG_R + 10);
    for (int b = 2; b < 4; b++) begin
      @(posedge clk) st[b] <= 1'b1;
      wait_oe(1, 5);
      @(posedge clk) st[b] <= 1'b0;
      wait_mode(MODE_SWITCHING, 300);
      wait_oe(0, PG_R + 10);
    end
    pulses(10 * DEF_PERIOD);
    chk("pulses", 10, n);
    @(posedge clk) st[6] <= 1'b1;
    cyc(200);
    pulses(10 * fold_per(DEF_PERIOD));
    chk("pulses", 10, n);
    @(posedge clk) st[6] <= 1'b0;
    cyc(200);
    @(posedge clk) run <= 1'b1;
    cyc(2000 * 25);
    chk("locked", 0, locked);
    chk("mode", MODE_SWITCHING, mode);
    for (int i = 0; i < 3000 && locked !== 1'b1; i++) @(negedge clk);
    chk("locked", 1, locked);
    // Spreading is a registered follower of the lock flag, one cycle behind.
    cyc(1);
    chk("spread", 0, spread);
    cyc(100 * 25);
    pulses(250);
    chk("pulses", 10, n);
    @(posedge clk) run <= 1'b0;
    cyc(600);
    chk("locked", 0, locked);
    // A 160 ns period burst started off the rising edge: each level is shorter than
    // the edge hold time, so neither lock nor enable may move.
    half <= 80;
    run <= 1'b1;
    cyc(600);
    chk("locked", 0, locked);
    chk("mode", MODE_SWITCHING, mode);
    @(posedge clk) run <= 1'b0;
    cyc(50);
    @(posedge clk) level <= 1'b0;
    cyc(150);
    chk("mode", MODE_SWITCHING, mode);
    wait_mode(MODE_STANDBY, 120);
    wait_oe(1, 5);
    close_out();
  end
endmodule : regulator_ctrl_tb_top
